// ==== common/blf_pkg.sv ====
package blf_pkg;

    // Register byte addresses on the Avalon-MM slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LOW_THR = 8'h08;
    localparam logic [7:0] REG_SD_SET = 8'h0C;
    localparam logic [7:0] REG_SD_CLR = 8'h10;
    localparam logic [7:0] REG_AT_RATE = 8'h14;
    localparam logic [7:0] REG_USER_MA = 8'h18;
    localparam logic [7:0] REG_USER_MW = 8'h1C;
    localparam logic [7:0] REG_DESIGN_CAP = 8'h20;
    localparam logic [7:0] REG_DESIGN_NRG = 8'h24;
    localparam logic [7:0] REG_REM_CAP = 8'h28;
    localparam logic [7:0] REG_LOAD = 8'h2C;
    localparam logic [7:0] REG_LAST_RUN = 8'h30;

    // Field positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_SEL_LSB = 8;
    localparam int SEL_W = 3;
    localparam int STAT_LOW_BIT = 0;
    localparam int STAT_SD_BIT = 1;
    localparam int STAT_MODE_BIT = 2;
    localparam int LAST_P_LSB = 16;

    // Reset values
    localparam logic [2:0] LOAD_SEL_RST = 3'h1;
    localparam logic [15:0] LOW_THR_RST = 16'h0096;
    localparam logic [15:0] SD_SET_RST = 16'h0C1C;
    localparam logic [15:0] SD_CLR_RST = 16'h0C80;
    localparam logic [15:0] DESIGN_CAP_RST = 16'h03E8;
    localparam logic [15:0] DESIGN_NRG_RST = 16'h0170;
    localparam logic [15:0] REM_CAP_RST = 16'h03E8;
    localparam logic [15:0] AVG_I_LAST_RST = 16'hFED4;
    localparam logic [15:0] AVG_P_LAST_RST = 16'hFB50;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // Timing and scaling
    localparam int UPDATE_PERIOD_S = 1;
    localparam int LPF_TAU_S = 14;
    localparam int LPF_STEPS = LPF_TAU_S / UPDATE_PERIOD_S;
    localparam int SEC_PER_HOUR = 3600;
    localparam int SENSE_RES_MOHM = 10;
    localparam int DESIGN_RATE_DIV = 5;
    localparam int POWER_SCALE = 10000;

    typedef enum logic {
        LM_CURRENT,
        LM_POWER
    } blf_mode_e;

    typedef enum logic [2:0] {
        SEL_LAST_RUN,
        SEL_PRESENT,
        SEL_AVERAGE,
        SEL_FILTERED,
        SEL_DESIGN,
        SEL_AT_RATE,
        SEL_USER
    } blf_sel_e;

    typedef enum logic {
        DS_IDLE,
        DS_ACTIVE
    } blf_dsg_e;

    // One measurement update; sense samples in microvolts, voltage in mV
    typedef struct packed {
        logic valid;
        logic signed [15:0] sense_positive_input;
        logic signed [15:0] sense_negative_input;
        logic [15:0] voltage;
        logic signed [15:0] average_current_b;
    } blf_meas_s;

endpackage

// ==== rtl/blf_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
module blf_divider import blf_pkg::*; #(
    parameter int NW = 32,
    parameter int DW = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [NW-1:0] dividend,
    input wire logic [DW-1:0] divisor,
    output logic done,
    output logic [NW-1:0] quotient
);
    localparam int CW = $clog2(NW + 1);
    localparam logic [CW-1:0] STEPS = CW'(NW);

    logic busy_q;
    logic [CW-1:0] cnt_q;
    logic [DW:0] rem_q;
    logic [DW-1:0] dvs_q;
    logic [DW:0] rem_sh;
    logic fits;

    assign rem_sh = {rem_q[DW-1:0], quotient[NW-1]};
    assign fits = rem_sh >= {1'b0, dvs_q};

    // Restarting mid-division is allowed; the newest operands win
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            rem_q <= '0;
            dvs_q <= '0;
            quotient <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q <= STEPS;
                rem_q <= '0;
                dvs_q <= divisor;
                quotient <= dividend;
            end else if (busy_q) begin
                rem_q <= fits ? rem_sh - {1'b0, dvs_q} : rem_sh;
                quotient <= {quotient[NW-2:0], fits};
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CW'(1)) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/blf_lpf.sv ====
`timescale 1ns/100ps
`default_nettype none
module blf_lpf import blf_pkg::*; #(
    parameter int STEPS = LPF_STEPS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic en,
    input wire logic signed [15:0] x,
    output logic signed [15:0] y
);
    logic signed [16:0] diff;

    assign diff = 17'(x) - 17'(y);

    // First-order filter, one step per measurement update
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            y <= '0;
        end else if (en) begin
            y <= 16'(17'(y) + 17'(diff / STEPS));
        end
    end
endmodule
`default_nettype wire

// ==== rtl/blf_gauge_flags.sv ====
// Operation
// - Set low_charge_flag when remaining capacity falls below low_charge_set_threshold.
// - Clear low_charge_flag when remaining capacity rises above that same threshold.
// - battery_low_pin always follows low_charge_flag.
// - Voltage below shutdown_set_voltage sets shutdown_warning_flag and pulses the interrupt pin.
// - Clear set shutdown_warning_flag only when voltage rises above shutdown_clear_voltage.
// - Clearing shutdown_warning_flag also pulses the interrupt pin.
// - Load model 0 (default) is constant current, 1 constant power.
// - load_model_status_bit mirrors the load model selector.
// - Current select 0 uses previous discharge cycle average current.
// - Current select 1 (default) uses present discharge cycle average current.
// - Current select 2 uses reported average current directly.
// - Current select 3 uses average current low-pass filtered, 14 s constant.
// - Current select 4 uses design capacity divided by five, in mA.
// - Current select 5 uses at-rate current; 6 uses user rate current.
// - Remaining capacity integrates charge sensed across the series sense resistor.
// - Power select 0 uses previous discharge cycle average power.
`timescale 1ns/100ps
`default_nettype none
module blf_gauge_flags import blf_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire blf_meas_s meas,
    output logic battery_low_pin,
    output logic soc_interrupt_pin
);
    // Configuration registers
    blf_mode_e mode_q;
    blf_sel_e sel_q;
    logic [15:0] low_thr_q;
    logic [15:0] sd_set_q;
    logic [15:0] sd_clr_q;
    logic [15:0] at_rate_q;
    logic [15:0] user_ma_q;
    logic [15:0] user_mw_q;
    logic [15:0] design_cap_q;
    logic [15:0] design_nrg_q;

    // Gauge state
    logic [15:0] remaining_capacity_a;
    logic signed [31:0] frac_q;
    logic low_charge_flag;
    logic shutdown_warning_flag;
    logic load_model_status_bit;
    blf_dsg_e dsg_q;
    logic [31:0] sum_i_q;
    logic [31:0] sum_p_q;
    logic [15:0] cnt_q;
    logic [15:0] last_i_q;
    logic [15:0] last_p_q;
    logic [15:0] pres_i_q;
    logic [15:0] pres_p_q;
    logic [15:0] load_q;

    // Bus side
    logic wr_en;
    logic rd_take;
    logic cap_wr;

    // Measurement side
    logic upd;
    logic signed [16:0] sense_diff;
    logic signed [15:0] i_ma;
    logic signed [31:0] volt_s;
    logic signed [15:0] p_10mw;
    logic signed [31:0] tot;
    logic signed [31:0] dq;
    logic signed [31:0] cap_sum;
    logic [15:0] cap_nx;
    logic dsg_now;
    logic div_start;
    logic div_i_done;
    logic div_p_done;
    logic [31:0] quo_i;
    logic [31:0] quo_p;
    logic signed [15:0] lpf_i;
    logic [15:0] load_d;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] scale_pw(input logic signed [15:0] cur,
                                             input logic signed [31:0] mv);
        logic signed [31:0] prod;
        prod = 32'(cur) * mv;
        scale_pw = 16'(prod / POWER_SCALE);
    endfunction

    // Read data is taken one edge after the request; a write lands on the edge that ends the waitrequest-low cycle
    assign wr_en = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && avs_waitrequest;
    assign cap_wr = wr_en && avs_address == REG_REM_CAP;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= '0;
        end else if (rd_take) begin
            case (avs_address)
                REG_CTRL: begin
                    avs_readdata <= 32'({sel_q, 7'h00, mode_q});
                end
                REG_STATUS: begin
                    avs_readdata <= 32'({load_model_status_bit, shutdown_warning_flag, low_charge_flag});
                end
                REG_LOW_THR: avs_readdata <= 32'(low_thr_q);
                REG_SD_SET: avs_readdata <= 32'(sd_set_q);
                REG_SD_CLR: avs_readdata <= 32'(sd_clr_q);
                REG_AT_RATE: avs_readdata <= 32'(at_rate_q);
                REG_USER_MA: avs_readdata <= 32'(user_ma_q);
                REG_USER_MW: avs_readdata <= 32'(user_mw_q);
                REG_DESIGN_CAP: avs_readdata <= 32'(design_cap_q);
                REG_DESIGN_NRG: avs_readdata <= 32'(design_nrg_q);
                REG_REM_CAP: avs_readdata <= 32'(remaining_capacity_a);
                REG_LOAD: avs_readdata <= 32'(load_q);
                REG_LAST_RUN: avs_readdata <= {last_p_q, last_i_q};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // Control word: byte 0 holds the model, byte 1 the load estimate select
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= LM_CURRENT;
            sel_q <= blf_sel_e'(LOAD_SEL_RST);
        end else if (wr_en && avs_address == REG_CTRL) begin
            if (avs_byteenable[0]) begin
                mode_q <= blf_mode_e'(avs_writedata[CTRL_MODE_BIT]);
            end
            if (avs_byteenable[1]) begin
                sel_q <= blf_sel_e'(avs_writedata[CTRL_SEL_LSB +: SEL_W]);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_thr_q <= LOW_THR_RST;
            sd_set_q <= SD_SET_RST;
            sd_clr_q <= SD_CLR_RST;
            at_rate_q <= ZERO16;
            user_ma_q <= ZERO16;
            user_mw_q <= ZERO16;
            design_cap_q <= DESIGN_CAP_RST;
            design_nrg_q <= DESIGN_NRG_RST;
        end else if (wr_en) begin
            case (avs_address)
                REG_LOW_THR: low_thr_q <= merge16(low_thr_q, avs_writedata, avs_byteenable);
                REG_SD_SET: sd_set_q <= merge16(sd_set_q, avs_writedata, avs_byteenable);
                REG_SD_CLR: sd_clr_q <= merge16(sd_clr_q, avs_writedata, avs_byteenable);
                REG_AT_RATE: at_rate_q <= merge16(at_rate_q, avs_writedata, avs_byteenable);
                REG_USER_MA: user_ma_q <= merge16(user_ma_q, avs_writedata, avs_byteenable);
                REG_USER_MW: user_mw_q <= merge16(user_mw_q, avs_writedata, avs_byteenable);
                REG_DESIGN_CAP: design_cap_q <= merge16(design_cap_q, avs_writedata, avs_byteenable);
                REG_DESIGN_NRG: design_nrg_q <= merge16(design_nrg_q, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
    end

    // Current through the sense resistor, positive while charging
    assign upd = meas.valid;
    assign sense_diff = 17'(meas.sense_positive_input) - 17'(meas.sense_negative_input);
    assign i_ma = 16'(sense_diff / SENSE_RES_MOHM);
    assign volt_s = $signed({16'h0000, meas.voltage});
    assign p_10mw = scale_pw(i_ma, volt_s);
    assign dsg_now = i_ma < 0;

    // Charge integration: fraction kept in mA-seconds, whole units carried into mAh
    always_comb begin
        tot = frac_q + 32'(i_ma) * UPDATE_PERIOD_S;
        dq = tot / SEC_PER_HOUR;
        cap_sum = $signed({16'h0000, remaining_capacity_a}) + dq;
        if (cap_sum < 0) begin
            cap_nx = ZERO16;
        end else if (cap_sum > $signed({16'h0000, CNT_MAX})) begin
            cap_nx = CNT_MAX;
        end else begin
            cap_nx = cap_sum[15:0];
        end
    end

    // A software preset of the capacity wins over a coincident update
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            remaining_capacity_a <= REM_CAP_RST;
            frac_q <= '0;
        end else if (cap_wr) begin
            remaining_capacity_a <= merge16(remaining_capacity_a, avs_writedata, avs_byteenable);
            frac_q <= '0;
        end else if (upd) begin
            remaining_capacity_a <= cap_nx;
            frac_q <= tot - dq * SEC_PER_HOUR;
        end
    end

    // Low-charge flag has no hysteresis: equal to the threshold keeps its state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_charge_flag <= 1'b0;
        end else if (upd) begin
            if (cap_nx < low_thr_q) begin
                low_charge_flag <= 1'b1;
            end else if (cap_nx > low_thr_q) begin
                low_charge_flag <= 1'b0;
            end
        end
    end

    // Pin lags the flag by one edge so it stays a plain flip-flop output
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            battery_low_pin <= 1'b0;
        end else begin
            battery_low_pin <= low_charge_flag;
        end
    end

    // Shutdown warning with separate set and clear voltages
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shutdown_warning_flag <= 1'b0;
            soc_interrupt_pin <= 1'b0;
        end else begin
            soc_interrupt_pin <= 1'b0;
            if (upd) begin
                if (!shutdown_warning_flag && meas.voltage < sd_set_q) begin
                    shutdown_warning_flag <= 1'b1;
                    soc_interrupt_pin <= 1'b1;
                end else if (shutdown_warning_flag && meas.voltage > sd_clr_q) begin
                    shutdown_warning_flag <= 1'b0;
                    soc_interrupt_pin <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_model_status_bit <= 1'b0;
        end else begin
            load_model_status_bit <= mode_q == LM_POWER;
        end
    end

    // Discharge cycle tracking; the running average becomes the last-run value at cycle end
    assign div_start = upd && dsg_now;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dsg_q <= DS_IDLE;
            sum_i_q <= '0;
            sum_p_q <= '0;
            cnt_q <= ZERO16;
            last_i_q <= AVG_I_LAST_RST;
            last_p_q <= AVG_P_LAST_RST;
        end else if (upd) begin
            case (dsg_q)
                DS_IDLE: begin
                    if (dsg_now) begin
                        dsg_q <= DS_ACTIVE;
                        sum_i_q <= 32'(-17'(i_ma));
                        sum_p_q <= 32'(-17'(p_10mw));
                        cnt_q <= 16'h0001;
                    end
                end
                DS_ACTIVE: begin
                    if (dsg_now) begin
                        sum_i_q <= sum_i_q + 32'(-17'(i_ma));
                        sum_p_q <= sum_p_q + 32'(-17'(p_10mw));
                        if (cnt_q != CNT_MAX) begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end else begin
                        dsg_q <= DS_IDLE;
                        last_i_q <= pres_i_q;
                        last_p_q <= pres_p_q;
                    end
                end
                default: dsg_q <= DS_IDLE;
            endcase
        end
    end

    // Divides see the sums before this update; the result trails by one sample
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pres_i_q <= AVG_I_LAST_RST;
            pres_p_q <= AVG_P_LAST_RST;
        end else begin
            if (div_i_done) begin
                pres_i_q <= 16'(-quo_i);
            end
            if (div_p_done) begin
                pres_p_q <= 16'(-quo_p);
            end
        end
    end

    blf_divider #(.NW(32), .DW(16)) u_div_i (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(div_start && cnt_q != ZERO16),
        .dividend(sum_i_q),
        .divisor(cnt_q),
        .done(div_i_done),
        .quotient(quo_i)
    );

    blf_divider #(.NW(32), .DW(16)) u_div_p (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(div_start && cnt_q != ZERO16),
        .dividend(sum_p_q),
        .divisor(cnt_q),
        .done(div_p_done),
        .quotient(quo_p)
    );

    blf_lpf #(.STEPS(LPF_STEPS)) u_lpf (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .en(upd),
        .x(meas.average_current_b),
        .y(lpf_i)
    );

    // Load estimate for compensated capacity; unused select code falls back to the default
    always_comb begin
        load_d = pres_i_q;
        if (mode_q == LM_CURRENT) begin
            case (sel_q)
                SEL_LAST_RUN: load_d = last_i_q;
                SEL_PRESENT: load_d = pres_i_q;
                SEL_AVERAGE: load_d = meas.average_current_b;
                SEL_FILTERED: load_d = lpf_i;
                SEL_DESIGN: load_d = design_cap_q / 16'(DESIGN_RATE_DIV);
                SEL_AT_RATE: load_d = at_rate_q;
                SEL_USER: load_d = user_ma_q;
                default: load_d = pres_i_q;
            endcase
        end else begin
            case (sel_q)
                SEL_LAST_RUN: load_d = last_p_q;
                SEL_PRESENT: load_d = pres_p_q;
                SEL_AVERAGE: load_d = scale_pw(meas.average_current_b, volt_s);
                SEL_FILTERED: load_d = scale_pw(lpf_i, volt_s);
                SEL_DESIGN: load_d = design_nrg_q / 16'(DESIGN_RATE_DIV);
                SEL_AT_RATE: load_d = at_rate_q;
                SEL_USER: load_d = user_mw_q;
                default: load_d = pres_p_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            load_q <= AVG_I_LAST_RST;
        end else begin
            load_q <= load_d;
        end
    end
endmodule
`default_nettype wire

// ==== test/blf_gauge_flags_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module blf_gauge_flags_chk import blf_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire blf_meas_s meas,
    input wire logic battery_low_pin,
    input wire logic soc_interrupt_pin
);
    logic sd_q;
    logic [15:0] set_q;
    logic [15:0] clr_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Shadow of the shutdown flag; byte lanes ignored, so partial threshold writes are not tracked
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sd_q <= 1'b0;
            set_q <= SD_SET_RST;
            clr_q <= SD_CLR_RST;
        end else begin
            if (soc_interrupt_pin) sd_q <= !sd_q;
            if (avs_write && !avs_waitrequest && avs_address == REG_SD_SET) set_q <= avs_writedata[15:0];
            if (avs_write && !avs_waitrequest && avs_address == REG_SD_CLR) clr_q <= avs_writedata[15:0];
        end
    end
    AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address == 8'h40
        |=> !avs_waitrequest && avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_INT_PULSE: assert property (soc_interrupt_pin |=> !soc_interrupt_pin)
        else $error("interrupt pin high two cycles");
    AST_INT_CAUSE: assert property (soc_interrupt_pin |-> $past(meas.valid))
        else $error("interrupt without measurement update");
    AST_LOW_PIN: assert property ($changed(battery_low_pin) |-> $past(meas.valid, 2))
        else $error("low pin moved without update");
    AST_SD_SET: assert property (meas.valid && !sd_q && meas.voltage < set_q |=> soc_interrupt_pin)
        else $error("shutdown set without interrupt");
    AST_SD_CLR: assert property (meas.valid && sd_q && meas.voltage > clr_q |=> soc_interrupt_pin)
        else $error("shutdown clear without interrupt");
    AST_SD_HOLD: assert property (meas.valid && (sd_q ? meas.voltage <= clr_q : meas.voltage >= set_q)
        |=> !soc_interrupt_pin) else $error("shutdown flag moved inside band");
endmodule
bind blf_gauge_flags blf_gauge_flags_chk chk_u (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .meas, .battery_low_pin, .soc_interrupt_pin);
`default_nettype wire

// ==== test/blf_mcu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module blf_mcu_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic soc_interrupt_pin,
    output int pulse_cnt
);
    // Counts every high cycle, so a stretched pulse shows up as an extra count
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_cnt <= 0;
        end else if (soc_interrupt_pin) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top import blf_pkg::*; ;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic avs_waitrequest;
    logic battery_low_pin;
    logic soc_interrupt_pin;
    blf_meas_s meas = '0;
    int error_cnt = 0;
    int n_tests = 0;
    int pulses;
    int exp_pulses = 0;
    int cap = 1000;
    int thr = 150;
    int n;
    logic low_m = 1'b0;
    logic sd_m = 1'b0;
    logic [7:0] ra[7] = '{REG_CTRL, REG_LOW_THR, REG_SD_SET, REG_SD_CLR, REG_REM_CAP, REG_LOAD, 8'h40};
    logic [31:0] rv[7] = '{32'h0100, 32'h0096, 32'h0C1C, 32'h0C80, 32'h03E8, 32'hFED4, 32'h0};
    // Select 3 after one update from zero: one step of a 14-update filter, 85/14 truncated
    logic [31:0] cw[7] = '{32'h0000, 32'h0200, 32'h0300, 32'h0400, 32'h0500, 32'h0600, 32'h0001};
    logic [31:0] ev[7] = '{32'hFED4, 32'h0055, 32'h0006, 32'h00C8, 32'h0123, 32'h0456, 32'hFB50};
    blf_gauge_flags dut_u (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .meas, .battery_low_pin, .soc_interrupt_pin);
    blf_mcu_model mcu_u (.sys_clk, .reset_n, .soc_interrupt_pin, .pulse_cnt(pulses));
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low, whatever the latency
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // One update: s steps of 3600 mA, i.e. s mAh per update
    task automatic upd(input logic [15:0] v, input int s);
        @(posedge sys_clk);
        meas <= '{1'b1, 16'(s * 18000), 16'(-s * 18000), v, 16'h0055};
        cap += s;
        if (cap < thr) low_m = 1'b1;
        else if (cap > thr) low_m = 1'b0;
        if ((!sd_m && v < SD_SET_RST) || (sd_m && v > SD_CLR_RST)) begin
            sd_m = !sd_m;
            exp_pulses++;
        end
        @(posedge sys_clk);
        meas.valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(battery_low_pin, low_m);
        chk(pulses, exp_pulses);
        // Spacing leaves room for the averaging divides
        repeat (36) @(posedge sys_clk);
    endtask
    initial begin
        void'($urandom(32'h00C8));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        bus(1'b1, 8'h40, 32'hFFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        upd(16'h0CE4, 0);
        bus(1'b1, REG_AT_RATE, 32'h0123);
        bus(1'b1, REG_USER_MA, 32'h0456);
        foreach (cw[i]) begin
            bus(1'b1, REG_CTRL, cw[i]);
            bus(1'b0, REG_LOAD, 32'h0);
            chk(rd, ev[i]);
        end
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        bus(1'b1, REG_CTRL, 32'h0100);
        upd(SD_SET_RST, 0);
        upd(16'h0BB8, 0);
        upd(SD_CLR_RST, 0);
        upd(16'h0CE4, 0);
        bus(1'b1, REG_REM_CAP, 32'h00C8);
        bus(1'b1, REG_LOW_THR, 32'h00C3);
        cap = 200;
        thr = 195;
        n = 5 + $urandom_range(3);
        for (int i = 0; i < 16; i++) begin
            upd(16'h0BB8 + 16'($urandom_range(299)), (i < n) ? -1 : 1);
        end
        bus(1'b0, REG_REM_CAP, 32'h0);
        chk(rd, 32'(cap));
        // Every discharge step draws 3600 mA, so both averages are -3600 mA
        bus(1'b0, REG_LOAD, 32'h0);
        chk(rd, 32'h0000F1F0);
        bus(1'b0, REG_LAST_RUN, 32'h0);
        chk(rd[15:0], 16'hF1F0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd, {29'h0, 1'b0, sd_m, low_m});
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
